// ---- src/sgwm_top.sv ----
// sgwm_top: wear supervision of one switchgear, registers over axi4-lite
// assumes event inputs are one-cycle pulses synchronous to clk; currents in amperes
`timescale 1ns/1ps
`default_nettype none
module sgwm_top #(
  parameter longint hour_len = sgwm_pkg::hour_cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // switchgear events
  input wire logic trip_event,
  input wire logic close_event,
  input wire logic [31:0] phase_current [3],
  input wire logic [31:0] travel_time,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // flags
  output logic [8:0] status_flags
);
  if (hour_len < 2) begin : g_bad_hour_len
    $error("hour_len too small");
  end
  // ----------------------------------------------------------------
  // configuration and state
  // ----------------------------------------------------------------
  logic [31:0] op_count, op_limit, sum_limit, hour_limit, close_lim, open_lim;
  logic [31:0] hour_sum, wear;
  // an hour at full clock rate does not fit 32 bits
  logic [63:0] hour_cnt, next_hour_cnt;
  logic hour_over;
  logic [31:0] psum [3];
  logic [3:0] npoints;
  logic [31:0] cur_i [sgwm_pkg::max_points];
  logic [31:0] cur_n [sgwm_pkg::max_points];
  logic slow, hour_alarm;
  logic [31:0] next_op_count, next_hour_sum, next_wear;
  logic [31:0] next_psum [3];
  logic next_slow, next_hour_alarm;
  // ----------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------
  logic aw_held, w_held, b_pend;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  assign s_awready = !aw_held && !b_pend;
  assign s_wready = !w_held && !b_pend;
  assign wr_addr = aw_held ? aw_addr : s_awaddr;
  assign wr_data = w_held ? w_data : s_wdata;
  assign do_write = (aw_held || (s_awvalid && s_awready)) && (w_held || (s_wvalid && s_wready));
  assign s_bvalid = b_pend;
  assign s_bresp = sgwm_pkg::resp_okay;
  function automatic logic is_curve(input logic [7:0] a, input logic [7:0] base);
    return a >= base && a < base + 8'(4 * sgwm_pkg::max_points);
  endfunction
  function automatic logic [3:0] curve_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[5:2];
  endfunction
  logic clear_pulse;
  assign clear_pulse = do_write && wr_addr == sgwm_pkg::off_ctrl && wr_data[sgwm_pkg::ctrl_clear];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      b_pend <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      op_limit <= sgwm_pkg::limit_reset;
      sum_limit <= sgwm_pkg::limit_reset;
      hour_limit <= sgwm_pkg::limit_reset;
      close_lim <= sgwm_pkg::limit_reset;
      open_lim <= sgwm_pkg::limit_reset;
      npoints <= 4'h0;
      for (int k = 0; k < sgwm_pkg::max_points; k++) begin
        cur_i[k] <= 32'h0;
        cur_n[k] <= 32'h0;
      end
    end else begin
      if (s_awvalid && s_awready && !do_write) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready && !do_write) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        b_pend <= 1'b1;
        case (wr_addr)
          sgwm_pkg::off_op_limit: op_limit <= wr_data;
          sgwm_pkg::off_sum_limit: sum_limit <= wr_data;
          sgwm_pkg::off_hour_limit: hour_limit <= wr_data;
          sgwm_pkg::off_close_lim: close_lim <= wr_data;
          sgwm_pkg::off_open_lim: open_lim <= wr_data;
          sgwm_pkg::off_npoints: npoints <= (wr_data[3:0] > 4'(sgwm_pkg::max_points))
            ? 4'(sgwm_pkg::max_points) : wr_data[3:0];
          default: begin
            if (is_curve(wr_addr, sgwm_pkg::off_curve_i)) begin
              cur_i[curve_idx(wr_addr, sgwm_pkg::off_curve_i)] <= wr_data;
            end
            if (is_curve(wr_addr, sgwm_pkg::off_curve_n)) begin
              cur_n[curve_idx(wr_addr, sgwm_pkg::off_curve_n)] <= wr_data;
            end
          end
        endcase
      end else if (b_pend && s_bready) begin
        b_pend <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // wear computation: find segment, interpolate, divide
  // ----------------------------------------------------------------
  sgwm_pkg::sgwm_state_t state, next_state;
  logic [31:0] imax, next_imax, allowed, next_allowed;
  logic [3:0] seg, next_seg;
  logic [47:0] quo, next_quo, rem, next_rem;
  logic [5:0] bit_i, next_bit_i;
  logic [31:0] i_ka, n_lo, n_hi, i_lo, i_hi, n_of;
  logic [63:0] interp;
  logic [47:0] dividend;
  assign i_ka = imax / 32'd1000;
  assign dividend = 48'(sgwm_pkg::wear_full_fx);
  always_comb begin
    n_lo = cur_n[seg];
    n_hi = (seg + 4'h1 == npoints - 4'h1) ? 32'h0 : cur_n[seg + 4'h1];
    i_lo = cur_i[seg];
    i_hi = cur_i[seg + 4'h1];
    interp = 64'(n_lo);
    if (i_hi > i_lo && n_lo > n_hi) begin
      interp = 64'(n_lo) - (64'(n_lo - n_hi) * 64'(i_ka - i_lo)) / 64'(i_hi - i_lo);
    end
    n_of = (npoints == 4'h1) ? 32'h0 : interp[31:0];
  end
  always_comb begin
    next_state = state;
    next_imax = imax;
    next_seg = seg;
    next_allowed = allowed;
    next_quo = quo;
    next_rem = rem;
    next_bit_i = bit_i;
    next_wear = wear;
    case (state)
      sgwm_pkg::sgwm_idle: begin
        if (trip_event && npoints != 4'h0) begin
          next_imax = phase_current[0];
          for (int p = 1; p < 3; p++) begin
            if (phase_current[p] > next_imax) next_imax = phase_current[p];
          end
          next_seg = 4'h0;
          next_state = sgwm_pkg::sgwm_find;
        end
      end
      sgwm_pkg::sgwm_find: begin
        if (i_ka > cur_i[npoints - 4'h1] || (npoints == 4'h1 && i_ka >= cur_i[0])) begin
          next_allowed = 32'h0;
          next_state = sgwm_pkg::sgwm_apply;
        end else if (i_ka <= cur_i[0] && seg == 4'h0) begin
          next_allowed = (npoints == 4'h1) ? 32'h0 : cur_n[0];
          next_state = sgwm_pkg::sgwm_apply;
        end else if (i_ka <= cur_i[seg + 4'h1]) begin
          next_allowed = n_of;
          next_state = sgwm_pkg::sgwm_apply;
        end else begin
          next_seg = seg + 4'h1;
        end
      end
      sgwm_pkg::sgwm_apply: begin
        if (allowed == 32'h0) begin
          next_wear = sgwm_pkg::wear_full_fx;
          next_state = sgwm_pkg::sgwm_idle;
        end else begin
          next_quo = 48'h0;
          next_rem = 48'h0;
          next_bit_i = 6'd47;
          next_state = sgwm_pkg::sgwm_div;
        end
      end
      sgwm_pkg::sgwm_div: begin
        // restoring division of 100<<16 by allowed, one bit per cycle
        next_rem = {rem[46:0], dividend[bit_i]};
        if (next_rem >= 48'(allowed)) begin
          next_rem = next_rem - 48'(allowed);
          next_quo = quo | (48'h1 << bit_i);
        end
        next_bit_i = bit_i - 6'd1;
        if (bit_i == 6'd0) begin
          next_wear = (48'(wear) + next_quo >= 48'(sgwm_pkg::wear_full_fx))
            ? sgwm_pkg::wear_full_fx : wear + next_quo[31:0];
          next_state = sgwm_pkg::sgwm_idle;
        end
      end
      default: next_state = sgwm_pkg::sgwm_idle;
    endcase
    if (clear_pulse) next_wear = 32'h0;
  end
  // ----------------------------------------------------------------
  // counters, sums, hourly window, slow flag
  // ----------------------------------------------------------------
  always_comb begin
    next_op_count = op_count;
    next_hour_sum = hour_sum;
    next_hour_cnt = hour_cnt + 64'h1;
    next_slow = slow;
    next_hour_alarm = hour_alarm;
    for (int p = 0; p < 3; p++) next_psum[p] = psum[p];
    if (trip_event || close_event) next_op_count = op_count + 32'h1;
    if (trip_event) begin
      for (int p = 0; p < 3; p++) next_psum[p] = psum[p] + phase_current[p];
      next_hour_sum = hour_sum + phase_current[0] + phase_current[1] + phase_current[2];
    end
    hour_over = next_hour_sum > hour_limit;
    if (hour_cnt >= 64'(hour_len - 1)) begin
      next_hour_cnt = 64'h0;
      next_hour_sum = 32'h0;
    end
    if (clear_pulse) begin
      next_op_count = 32'h0;
      next_hour_sum = 32'h0;
      next_slow = 1'b0;
      next_hour_alarm = 1'b0;
      for (int p = 0; p < 3; p++) next_psum[p] = 32'h0;
    end
    // a flag raised by an event in the clearing cycle survives the clear
    if (hour_over && (trip_event || !clear_pulse)) next_hour_alarm = 1'b1;
    if (trip_event && travel_time > open_lim) next_slow = 1'b1;
    if (close_event && travel_time > close_lim) next_slow = 1'b1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= sgwm_pkg::sgwm_idle;
      imax <= 32'h0;
      seg <= 4'h0;
      allowed <= 32'h0;
      quo <= 48'h0;
      rem <= 48'h0;
      bit_i <= 6'd0;
      wear <= 32'h0;
      op_count <= 32'h0;
      hour_sum <= 32'h0;
      hour_cnt <= 64'h0;
      slow <= 1'b0;
      hour_alarm <= 1'b0;
      for (int p = 0; p < 3; p++) psum[p] <= 32'h0;
    end else begin
      state <= next_state;
      imax <= next_imax;
      seg <= next_seg;
      allowed <= next_allowed;
      quo <= next_quo;
      rem <= next_rem;
      bit_i <= next_bit_i;
      wear <= next_wear;
      op_count <= next_op_count;
      hour_sum <= next_hour_sum;
      hour_cnt <= next_hour_cnt;
      slow <= next_slow;
      hour_alarm <= next_hour_alarm;
      for (int p = 0; p < 3; p++) psum[p] <= next_psum[p];
    end
  end
  // ----------------------------------------------------------------
  // flags and read path
  // ----------------------------------------------------------------
  logic [8:0] flags;
  always_comb begin
    flags = 9'h0;
    flags[sgwm_pkg::st_op_alarm] = op_count > op_limit;
    for (int p = 0; p < 3; p++) flags[sgwm_pkg::st_phase_alarm + p] = psum[p] > sum_limit;
    flags[sgwm_pkg::st_sum_alarm] = |flags[4:2];
    flags[sgwm_pkg::st_slow] = slow;
    flags[sgwm_pkg::st_wear_alarm] = wear >= sgwm_pkg::wear_full_fx;
    flags[sgwm_pkg::st_hour_alarm] = hour_alarm;
    flags[sgwm_pkg::st_maint] = wear >= sgwm_pkg::wear_full_fx;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) status_flags <= 9'h0;
    else status_flags <= flags;
  end
  assign s_arready = !s_rvalid;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= sgwm_pkg::resp_okay;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= sgwm_pkg::resp_okay;
      case (s_araddr)
        sgwm_pkg::off_status: s_rdata <= {23'h0, flags};
        sgwm_pkg::off_op_count: s_rdata <= op_count;
        sgwm_pkg::off_op_limit: s_rdata <= op_limit;
        sgwm_pkg::off_sum_base: s_rdata <= psum[0];
        sgwm_pkg::off_sum_base + 8'h04: s_rdata <= psum[1];
        sgwm_pkg::off_sum_base + 8'h08: s_rdata <= psum[2];
        sgwm_pkg::off_sum_limit: s_rdata <= sum_limit;
        sgwm_pkg::off_hour_sum: s_rdata <= hour_sum;
        sgwm_pkg::off_hour_limit: s_rdata <= hour_limit;
        sgwm_pkg::off_wear: s_rdata <= wear;
        sgwm_pkg::off_close_lim: s_rdata <= close_lim;
        sgwm_pkg::off_open_lim: s_rdata <= open_lim;
        sgwm_pkg::off_npoints: s_rdata <= {28'h0, npoints};
        sgwm_pkg::off_ctrl: s_rdata <= 32'h0;
        default: begin
          s_rdata <= 32'h0;
          if (is_curve(s_araddr, sgwm_pkg::off_curve_i)) begin
            s_rdata <= cur_i[curve_idx(s_araddr, sgwm_pkg::off_curve_i)];
          end else if (is_curve(s_araddr, sgwm_pkg::off_curve_n)) begin
            s_rdata <= cur_n[curve_idx(s_araddr, sgwm_pkg::off_curve_n)];
          end else begin
            s_rresp <= sgwm_pkg::resp_slverr;
          end
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_count;
    @(posedge clk) disable iff (!reset_n)
    (trip_event && !clear_pulse) |=> op_count == $past(op_count) + 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("count not advanced");
  property p_op_alarm;
    @(posedge clk) disable iff (!reset_n)
    (op_count > op_limit) |=> status_flags[0];
  endproperty
  a_op_alarm: assert property (p_op_alarm) else $error("operation alarm missing");
  property p_sum_alarm;
    @(posedge clk) disable iff (!reset_n)
    (psum[1] > sum_limit) |=> status_flags[1] && status_flags[3];
  endproperty
  a_sum_alarm: assert property (p_sum_alarm) else $error("sum alarm missing");
  property p_slow;
    @(posedge clk) disable iff (!reset_n)
    (close_event && travel_time > close_lim && !clear_pulse) |=> ##1 status_flags[5];
  endproperty
  a_slow: assert property (p_slow) else $error("slow flag missing");
  property p_wear_cap;
    @(posedge clk) disable iff (!reset_n) wear <= sgwm_pkg::wear_full_fx;
  endproperty
  a_wear_cap: assert property (p_wear_cap) else $error("wear above full");
  property p_zero_full;
    @(posedge clk) disable iff (!reset_n)
    (state == sgwm_pkg::sgwm_apply && allowed == 32'h0 && !clear_pulse)
      |=> wear == sgwm_pkg::wear_full_fx;
  endproperty
  a_zero_full: assert property (p_zero_full) else $error("zero allowed not full wear");
  property p_wear_alarm;
    @(posedge clk) disable iff (!reset_n)
    (wear == sgwm_pkg::wear_full_fx) |=> status_flags[6] && status_flags[8];
  endproperty
  a_wear_alarm: assert property (p_wear_alarm) else $error("wear alarm missing");
  property p_wear_mono;
    @(posedge clk) disable iff (!reset_n)
    !clear_pulse |=> wear >= $past(wear);
  endproperty
  a_wear_mono: assert property (p_wear_mono) else $error("wear decreased");
  property p_div_len;
    @(posedge clk) disable iff (!reset_n)
    (state == sgwm_pkg::sgwm_apply && allowed != 32'h0) |=> ##48 state == sgwm_pkg::sgwm_idle;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length wrong");
  c_trip: cover property (@(posedge clk) trip_event);
  c_full: cover property (@(posedge clk) status_flags[8]);
  c_hour: cover property (@(posedge clk) status_flags[7]);
endmodule // sgwm_top
`default_nettype wire

// ---- src/sgwm_pkg.sv ----
// sgwm_pkg: constants, register map and field layout of the switchgear wear monitor
// assumes the monitor sits behind an axi4-lite slave with 32-bit data
package sgwm_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_status = 8'h04;
  localparam logic [7:0] off_op_count = 8'h08;
  localparam logic [7:0] off_op_limit = 8'h0c;
  localparam logic [7:0] off_sum_base = 8'h10;
  localparam logic [7:0] off_sum_limit = 8'h1c;
  localparam logic [7:0] off_hour_sum = 8'h20;
  localparam logic [7:0] off_hour_limit = 8'h24;
  localparam logic [7:0] off_wear = 8'h28;
  localparam logic [7:0] off_close_lim = 8'h2c;
  localparam logic [7:0] off_open_lim = 8'h30;
  localparam logic [7:0] off_npoints = 8'h34;
  localparam logic [7:0] off_curve_i = 8'h40;
  localparam logic [7:0] off_curve_n = 8'h80;
  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int st_op_alarm = 0;
  localparam int st_sum_alarm = 1;
  localparam int st_phase_alarm = 2;
  localparam int st_slow = 5;
  localparam int st_wear_alarm = 6;
  localparam int st_hour_alarm = 7;
  localparam int st_maint = 8;
  // ctrl bit 0 clears counters and wear
  localparam int ctrl_clear = 0;
  // ----------------------------------------------------------------
  // values and timing
  // ----------------------------------------------------------------
  localparam int wear_full = 100;
  localparam int wear_frac = 16;
  localparam logic [31:0] wear_full_fx = 32'h0064_0000;
  localparam int max_points = 10;
  // limits come out of reset at their top value so no alarm fires before setup
  localparam logic [31:0] limit_reset = 32'hffff_ffff;
  localparam int clk_mhz = 200;
  localparam int hour_s = 3600;
  localparam longint hour_cycles = longint'(hour_s) * clk_mhz * 1000000;
  localparam logic [7:0] bresp_okay = 8'h00;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum {sgwm_idle, sgwm_find, sgwm_div, sgwm_apply} sgwm_state_t;
endpackage

// ---- tb/sgwm_breaker_model.sv ----
// sgwm_breaker_model: breaker contacts and phase current measurement facing the monitor
// assumes one bench request at a time, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sgwm_breaker_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // operation request from the bench
  input wire logic req,
  input wire logic req_trip,
  input wire logic [31:0] req_cur [3],
  input wire logic [31:0] req_travel,
  // measured side
  output logic trip_event,
  output logic close_event,
  output logic [31:0] phase_current [3],
  output logic [31:0] travel_time
);
  logic run;
  logic kind;
  logic [31:0] cnt;
  logic [31:0] trav;
  logic [31:0] cur [3];
  // -----------------------------------------------------------------
  // contacts move for the travel time, then report once
  // -----------------------------------------------------------------
  // values are only valid with the pulse; they toggle otherwise so late sampling shows
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      trip_event <= 1'b0;
      close_event <= 1'b0;
      phase_current <= '{default: 32'h0};
      travel_time <= 32'h0;
    end else begin
      trip_event <= 1'b0;
      close_event <= 1'b0;
      for (int k = 0; k < 3; k++) phase_current[k] <= ~phase_current[k];
      travel_time <= ~travel_time;
      if (req) begin
        run <= 1'b1;
        kind <= req_trip;
        cnt <= req_travel;
        trav <= req_travel;
        cur <= req_cur;
      end else if (run && cnt == 32'h0) begin
        run <= 1'b0;
        trip_event <= kind;
        close_event <= !kind;
        phase_current <= cur;
        travel_time <= trav;
      end else if (run) begin
        cnt <= cnt - 32'h1;
      end
    end
  end
endmodule // sgwm_breaker_model
`default_nettype wire

// ---- tb/switchgear_wear_monitor_tb_top.sv ----
// switchgear_wear_monitor_tb_top: self-checking bench of the wear monitor
// assumes sgwm_pkg, sgwm_top and sgwm_breaker_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module switchgear_wear_monitor_tb_top;
  logic clk, reset_n, req, req_trip, trip_event, close_event;
  logic [31:0] c [3];
  logic [31:0] phase_current [3];
  logic [31:0] exp_sum [3];
  logic [31:0] req_travel, travel_time, s_wdata, s_rdata, rd, exp_wear, amps;
  logic [7:0] s_awaddr, s_araddr;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, t;
  logic [8:0] status_flags;
  integer seed = 71817;
  int err_total, total_checks, n_ops;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sgwm_top #(.hour_len(2000)) u_dut (.clk(clk), .reset_n(reset_n), .trip_event(trip_event),
    .close_event(close_event), .phase_current(phase_current), .travel_time(travel_time),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .status_flags(status_flags));
  sgwm_breaker_model u_brk (.clk(clk), .reset_n(reset_n), .req(req), .req_trip(req_trip),
    .req_cur(c), .req_travel(req_travel), .trip_event(trip_event), .close_event(close_event),
    .phase_current(phase_current), .travel_time(travel_time));
  // -----------------------------------------------------------------
  // reporting
  // -----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    err_total++;
    $display("mismatch %s expected answer seen none", nm);
    finish_test();
  endtask
  // -----------------------------------------------------------------
  // axi4-lite master and breaker requests
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        s_bready <= 1'b0;
        chk("bresp", 32'h0, {30'h0, s_bresp});
        return;
      end
    end
    hang("write");
  endtask
  task automatic rd_raw(input logic [7:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd_raw(a);
    chk(nm, e, rd);
    chk("rresp", {30'h0, sgwm_pkg::resp_okay}, {30'h0, rr});
  endtask
  // currents are taken from c; waits past the wear engine settling time
  task automatic op(input logic trip, input logic [31:0] trav);
    @(posedge clk);
    req <= 1'b1;
    req_trip <= trip;
    req_travel <= trav;
    @(posedge clk);
    req <= 1'b0;
    repeat (trav + 80) @(posedge clk);
  endtask
  // curve loaded below: 1 kA allows 8, 9 kA is last point so allows none
  function automatic logic [31:0] wear_add(input logic [31:0] a);
    logic [31:0] ka;
    ka = a / 1000;
    if (ka >= 9) return sgwm_pkg::wear_full_fx;
    if (ka <= 1) return sgwm_pkg::wear_full_fx / 8;
    return sgwm_pkg::wear_full_fx / (8 - (ka - 1));
  endfunction
  initial begin
    repeat (100000) @(posedge clk);
    hang("run");
  end
  initial begin
    {reset_n, req, req_trip, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, req_travel} = '0;
    s_wstrb = 4'hf;
    c = '{default: 32'h0};
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk("op limit", sgwm_pkg::off_op_limit, 32'hffff_ffff);
    rd_chk("npoints", sgwm_pkg::off_npoints, 32'h0);
    wr(sgwm_pkg::off_npoints, 32'hf);
    rd_chk("npoints clip", sgwm_pkg::off_npoints, 32'(sgwm_pkg::max_points));
    wr(sgwm_pkg::off_npoints, 32'h0);
    rd_raw(8'hfc);
    chk("unmapped resp", {30'h0, sgwm_pkg::resp_slverr}, {30'h0, rr});
    $display("test reset done");
    wr(sgwm_pkg::off_op_limit, 32'h3);
    wr(sgwm_pkg::off_sum_limit, 32'h5dc);
    n_ops = 3 + ($unsigned($random(seed)) % 4);
    exp_sum = '{default: 32'h0};
    for (int k = 0; k < n_ops; k++) begin
      t = (k == 0) ? 1'b1 : $random(seed);
      for (int j = 0; j < 3; j++) c[j] = $unsigned($random(seed)) % 1000;
      op(t, 5 + $unsigned($random(seed)) % 20);
      if (t) for (int j = 0; j < 3; j++) exp_sum[j] += c[j];
    end
    rd_chk("op count", sgwm_pkg::off_op_count, n_ops);
    chk("op alarm", n_ops > 3, status_flags[0]);
    for (int j = 0; j < 3; j++) begin
      rd_chk("phase sum", sgwm_pkg::off_sum_base + 8'(4 * j), exp_sum[j]);
      chk("phase alarm", exp_sum[j] > 1500, status_flags[2 + j]);
    end
    chk("sum alarm", |{exp_sum[0] > 1500, exp_sum[1] > 1500, exp_sum[2] > 1500},
      status_flags[1]);
    $display("test random operations done");
    wr(sgwm_pkg::off_ctrl, 32'h1);
    rd_chk("cleared count", sgwm_pkg::off_op_count, 32'h0);
    wr(sgwm_pkg::off_open_lim, 32'd50);
    wr(sgwm_pkg::off_close_lim, 32'd40);
    c = '{default: 32'h0};
    op(1'b1, 32'd50);
    op(1'b0, 32'd40);
    chk("slow at limits", 32'h0, status_flags[5]);
    op(1'b0, 32'd41);
    chk("slow close", 32'h1, status_flags[5]);
    wr(sgwm_pkg::off_ctrl, 32'h1);
    op(1'b1, 32'd51);
    chk("slow open", 32'h1, status_flags[5]);
    $display("test slow operation done");
    wr(sgwm_pkg::off_curve_i, 32'd1);
    wr(sgwm_pkg::off_curve_n, 32'd8);
    wr(sgwm_pkg::off_curve_i + 8'h4, 32'd9);
    wr(sgwm_pkg::off_curve_n + 8'h4, 32'd5);
    wr(sgwm_pkg::off_npoints, 32'd2);
    for (int k = 0; k < 4; k++) begin
      wr(sgwm_pkg::off_ctrl, (k == 0 || k == 3) ? 32'h1 : 32'h0);
      if (k == 0 || k == 3) exp_wear = 32'h0;
      amps = (k == 3) ? 32'd20000 : 32'd1000 + 32'(4000 * k);
      c = '{default: amps};
      op(1'b1, 32'd10);
      exp_wear += wear_add(amps);
      if (exp_wear > sgwm_pkg::wear_full_fx) exp_wear = sgwm_pkg::wear_full_fx;
      rd_chk("wear", sgwm_pkg::off_wear, exp_wear);
      chk("maintenance", exp_wear == sgwm_pkg::wear_full_fx, status_flags[8]);
      chk("wear alarm", exp_wear == sgwm_pkg::wear_full_fx, status_flags[6]);
    end
    $display("test wear curve done");
    wr(sgwm_pkg::off_ctrl, 32'h1);
    wr(sgwm_pkg::off_hour_limit, 32'd500);
    chk("hourly idle", 32'h0, status_flags[7]);
    c = '{32'd600, 32'd0, 32'd0};
    op(1'b1, 32'd10);
    chk("hourly alarm", 32'h1, status_flags[7]);
    repeat (2000) @(posedge clk);
    rd_chk("hourly window", sgwm_pkg::off_hour_sum, 32'h0);
    chk("hourly sticky", 32'h1, status_flags[7]);
    $display("test hourly sum done");
    finish_test();
  end
endmodule // switchgear_wear_monitor_tb_top
`default_nettype wire
